//--- edcm_regs.svh
/*
 * Register map, field positions, reset values and thresholds of the
 * Ethernet DMA control and monitor block.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
`ifndef EDCM_REGS_SVH
`define EDCM_REGS_SVH

// byte offsets
`define EDCM_OFF_MODE        8'h00
`define EDCM_OFF_FIFO_DEPTH  8'h04
`define EDCM_OFF_OPCTL       8'h08
`define EDCM_OFF_RX_BUF      8'h0C
`define EDCM_OFF_RX_DESC     8'h10
`define EDCM_OFF_TX_BUF      8'h14
`define EDCM_OFF_TX_DESC     8'h18
`define EDCM_OFF_FC_THR      8'h1C
`define EDCM_OFF_INT_STAT    8'h20
`define EDCM_OFF_INT_MASK    8'h24

// dma_mode_register
`define EDCM_SOFT_RST_BIT    0
// fifo_depth_register
`define EDCM_RX_CAP_LSB      0
`define EDCM_TX_CAP_LSB      8
// dma_operation_control
`define EDCM_HALT_BIT        1
`define EDCM_AERR_BIT        2
`define EDCM_FIFO_HALT_BIT   3
// flow_control_threshold
`define EDCM_BYTE_THR_LSB    0
`define EDCM_FRM_THR_LSB     16
`define EDCM_FRM_THR_RESET   3'h7
`define EDCM_BYTE_THR_RESET  3'h0
`define EDCM_CAP_RESET       3'h0
// capacity and byte threshold codes
`define EDCM_CODE_256        3'h0
`define EDCM_CODE_512        3'h1
`define EDCM_LARGE_VARIANT   1'b1
`define EDCM_DEPTH_256       10'h100
`define EDCM_DEPTH_512       10'h200
`define EDCM_HEADROOM        10'h040
// interrupt status bits
`define EDCM_IRQ_FIFO_ERR    0
`define EDCM_IRQ_ADDR_ERR    1
`define EDCM_IRQ_NMI_HALT    2
`define EDCM_IRQ_FLOW_CTL    3
`define EDCM_IRQ_W           4

`endif

//--- edcm_pkg.sv
/*
 * Types shared by the Ethernet DMA control and monitor block.
 * Assumes edcm_regs.svh is on the include path.
 */
`default_nettype none
package edcm_pkg;
    // address snapshot from the transfer engine
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } edcm_addr_mon_s;
    // interrupt status or mask word
    typedef logic [3:0] edcm_irq_t;
endpackage
`default_nettype wire

//--- edcm_top.sv
/*
 * Control, status, address monitor and flow-control threshold logic of
 * an Ethernet DMA engine, reached over APB.
 * Assumes all inputs are synchronous to CORE_CLK and that the engine
 * obeys DMA_RUN and the MAC sends a PAUSE frame while PAUSE_REQ is high.
 */
`include "edcm_regs.svh"
`default_nettype none

module edcm_top (
    // clock and reset
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST_N,
    // apb slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [7:0]               PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic      [31:0]              PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    // engine events
    input  wire logic                     TX_UNDERFLOW,
    input  wire logic                     RX_OVERFLOW,
    input  wire logic                     ADDR_ILLEGAL,
    input  wire logic                     NMI,
    // address snapshots
    input  wire edcm_pkg::edcm_addr_mon_s RX_BUF_MON,
    input  wire edcm_pkg::edcm_addr_mon_s RX_DESC_MON,
    input  wire edcm_pkg::edcm_addr_mon_s TX_BUF_MON,
    input  wire edcm_pkg::edcm_addr_mon_s TX_DESC_MON,
    // receive fifo fill
    input  wire logic [9:0]               RX_FIFO_BYTES,
    input  wire logic [3:0]               RX_FIFO_FRAMES,
    // control outputs
    output logic                          DMA_RUN,
    output logic                          PAUSE_REQ,
    output logic                          IRQ
);
    import edcm_pkg::*;

    logic [2:0]  rx_cap;
    logic [2:0]  tx_cap;
    logic        fifo_error_halt_select;
    logic        address_error_flag;
    logic        halted_status;
    logic [31:0] rx_buffer_write_address;
    logic [31:0] rx_descriptor_fetch_address;
    logic [31:0] tx_buffer_read_address;
    logic [31:0] tx_descriptor_fetch_address;
    logic [2:0]  frame_count_threshold;
    logic [2:0]  byte_threshold_code;
    edcm_irq_t   int_status;
    edcm_irq_t   int_mask;
    logic        nmi_prev;
    logic        setup;
    logic        wr_en;
    logic        software_reset_bit;
    logic        eng_clr;
    logic        nmi_rise;
    logic        fifo_err;
    logic        fifo_halt;
    logic        halt_wr_zero;
    logic        byte_hit;
    logic        frame_hit;
    logic        next_pause;
    logic [31:0] next_rdata;
    logic        next_slverr;
    edcm_irq_t   irq_set;

    // byte level that starts flow control for a threshold code
    function automatic logic [9:0] byte_limit(input logic [2:0] code);
        if (code == `EDCM_CODE_512 && `EDCM_LARGE_VARIANT) begin
            return `EDCM_DEPTH_512 - `EDCM_HEADROOM;
        end
        return `EDCM_DEPTH_256 - `EDCM_HEADROOM;
    endfunction

    // whether a word address hits a given register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // apb decode: writes land on the completing access edge only
    assign setup    = PSEL & ~PENABLE;
    assign wr_en    = PSEL & PENABLE & PWRITE & PREADY;
    assign software_reset_bit = wr_en & hit(PADDR, `EDCM_OFF_MODE)
                              & PWDATA[`EDCM_SOFT_RST_BIT];
    assign eng_clr  = ~RST_N | software_reset_bit;
    assign halt_wr_zero = wr_en & hit(PADDR, `EDCM_OFF_OPCTL)
                        & ~PWDATA[`EDCM_HALT_BIT];
    // nmi is a level; only its rising edge halts, so a held pin
    // cannot lock out the restart
    assign nmi_rise  = NMI & ~nmi_prev;
    assign fifo_err  = TX_UNDERFLOW | RX_OVERFLOW;
    assign fifo_halt = fifo_err & fifo_error_halt_select;

    // flow control thresholds, either one suffices
    assign byte_hit  = RX_FIFO_BYTES >= byte_limit(byte_threshold_code);
    assign frame_hit = RX_FIFO_FRAMES
                     >= ({1'b0, frame_count_threshold} + 4'h1);
    assign next_pause = byte_hit | frame_hit;

    // interrupt event sources
    always_comb begin
        irq_set = '0;
        irq_set[`EDCM_IRQ_FIFO_ERR] = fifo_err;
        irq_set[`EDCM_IRQ_ADDR_ERR] = ADDR_ILLEGAL;
        irq_set[`EDCM_IRQ_NMI_HALT] = nmi_rise;
        irq_set[`EDCM_IRQ_FLOW_CTL] = next_pause & ~PAUSE_REQ;
    end

    // read mux; reserved bits stay zero by construction
    always_comb begin
        next_rdata  = '0;
        next_slverr = 1'b0;
        unique case (PADDR)
            `EDCM_OFF_MODE: ; // reset bit is self-clearing, reads zero
            `EDCM_OFF_FIFO_DEPTH: begin
                next_rdata[`EDCM_RX_CAP_LSB +: 3] = rx_cap;
                next_rdata[`EDCM_TX_CAP_LSB +: 3] = tx_cap;
            end
            `EDCM_OFF_OPCTL: begin
                next_rdata[`EDCM_FIFO_HALT_BIT] = fifo_error_halt_select;
                next_rdata[`EDCM_AERR_BIT] = address_error_flag;
                next_rdata[`EDCM_HALT_BIT] = halted_status;
            end
            `EDCM_OFF_RX_BUF: begin
                next_rdata  = rx_buffer_write_address;
                next_slverr = PWRITE;
            end
            `EDCM_OFF_RX_DESC: begin
                next_rdata  = rx_descriptor_fetch_address;
                next_slverr = PWRITE;
            end
            `EDCM_OFF_TX_BUF: begin
                next_rdata  = tx_buffer_read_address;
                next_slverr = PWRITE;
            end
            `EDCM_OFF_TX_DESC: begin
                next_rdata  = tx_descriptor_fetch_address;
                next_slverr = PWRITE;
            end
            `EDCM_OFF_FC_THR: begin
                next_rdata[`EDCM_FRM_THR_LSB +: 3] = frame_count_threshold;
                next_rdata[`EDCM_BYTE_THR_LSB +: 3] = byte_threshold_code;
            end
            `EDCM_OFF_INT_STAT: next_rdata[`EDCM_IRQ_W-1:0] = int_status;
            `EDCM_OFF_INT_MASK: next_rdata[`EDCM_IRQ_W-1:0] = int_mask;
            default: next_slverr = 1'b1;
        endcase
    end

    // apb answer: registered at the setup edge, zero wait states
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PRDATA  <= setup && !PWRITE ? next_rdata : 32'h00000000;
            PSLVERR <= setup & next_slverr;
        end
    end

    // configuration registers survive a software reset
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rx_cap                <= `EDCM_CAP_RESET;
            tx_cap                <= `EDCM_CAP_RESET;
            frame_count_threshold <= `EDCM_FRM_THR_RESET;
            byte_threshold_code   <= `EDCM_BYTE_THR_RESET;
            int_mask              <= '0;
        end else if (wr_en) begin
            if (hit(PADDR, `EDCM_OFF_FIFO_DEPTH)) begin
                rx_cap <= PWDATA[`EDCM_RX_CAP_LSB +: 3];
                tx_cap <= PWDATA[`EDCM_TX_CAP_LSB +: 3];
            end
            if (hit(PADDR, `EDCM_OFF_FC_THR)) begin
                frame_count_threshold <= PWDATA[`EDCM_FRM_THR_LSB +: 3];
                byte_threshold_code   <= PWDATA[`EDCM_BYTE_THR_LSB +: 3];
            end
            if (hit(PADDR, `EDCM_OFF_INT_MASK)) begin
                int_mask <= PWDATA[`EDCM_IRQ_W-1:0];
            end
        end
    end

    // operation control: fifo error select is plain read/write
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            fifo_error_halt_select <= 1'b0;
        end else if (wr_en && hit(PADDR, `EDCM_OFF_OPCTL)) begin
            fifo_error_halt_select <= PWDATA[`EDCM_FIFO_HALT_BIT];
        end
    end

    // address error: sticky, writes ignored, only hardware reset or soft reset clears
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            address_error_flag <= 1'b0;
        end else if (ADDR_ILLEGAL) begin
            address_error_flag <= 1'b1;
        end
    end

    // halted: new halt cause beats a same-cycle write of zero
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            halted_status <= 1'b0;
        end else if (nmi_rise || fifo_halt) begin
            halted_status <= 1'b1;
        end else if (halt_wr_zero) begin
            halted_status <= 1'b0;
        end
    end

    // nmi edge history
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            nmi_prev <= 1'b0;
        end else begin
            nmi_prev <= NMI;
        end
    end

    // run enable to the engine, one cycle behind the flags
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            DMA_RUN <= 1'b0;
        end else begin
            DMA_RUN <= ~halted_status & ~address_error_flag;
        end
    end

    // address snapshots; sampled copies, so they can trail the engine
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            rx_buffer_write_address     <= '0;
            rx_descriptor_fetch_address <= '0;
            tx_buffer_read_address      <= '0;
            tx_descriptor_fetch_address <= '0;
        end else begin
            if (RX_BUF_MON.valid) begin
                rx_buffer_write_address <= RX_BUF_MON.addr;
            end
            if (RX_DESC_MON.valid) begin
                rx_descriptor_fetch_address <= RX_DESC_MON.addr;
            end
            if (TX_BUF_MON.valid) begin
                tx_buffer_read_address <= TX_BUF_MON.addr;
            end
            if (TX_DESC_MON.valid) begin
                tx_descriptor_fetch_address <= TX_DESC_MON.addr;
            end
        end
    end

    // pause request to the mac follows the threshold level
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PAUSE_REQ <= 1'b0;
        end else begin
            PAUSE_REQ <= next_pause;
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge CORE_CLK) begin
        if (eng_clr) begin
            int_status <= '0;
        end else if (wr_en && hit(PADDR, `EDCM_OFF_INT_STAT)) begin
            int_status <= (int_status & ~PWDATA[`EDCM_IRQ_W-1:0]) | irq_set;
        end else begin
            int_status <= int_status | irq_set;
        end
    end

    // level interrupt, one cycle behind status
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_halted_stops;
        halted_status ##1 !DMA_RUN;
    endsequence

    property p_fifo_halt;
        fifo_err && fifo_error_halt_select && !software_reset_bit
            |=> s_halted_stops;
    endproperty
    a_fifo_halt: assert property (p_fifo_halt)
        else $error("fifo error with halt select did not halt");

    property p_fifo_continue;
        fifo_err && !fifo_error_halt_select && !halted_status
            && !nmi_rise && !software_reset_bit |=> !halted_status;
    endproperty
    a_fifo_continue: assert property (p_fifo_continue)
        else $error("fifo error halted with halt select clear");

    property p_aerr_stop;
        ADDR_ILLEGAL && !software_reset_bit
            |=> address_error_flag ##1 !DMA_RUN;
    endproperty
    a_aerr_stop: assert property (p_aerr_stop)
        else $error("address error did not stop the engine");

    property p_aerr_sticky;
        address_error_flag && !software_reset_bit |=> address_error_flag;
    endproperty
    a_aerr_sticky: assert property (p_aerr_sticky)
        else $error("address error flag cleared without soft reset");

    property p_nmi_halt;
        nmi_rise && !software_reset_bit |=> s_halted_stops;
    endproperty
    a_nmi_halt: assert property (p_nmi_halt)
        else $error("nmi did not halt the engine");

    property p_restart;
        halted_status && halt_wr_zero && !nmi_rise && !fifo_halt
            && !address_error_flag && !ADDR_ILLEGAL
            |=> !halted_status ##1 DMA_RUN;
    endproperty
    a_restart: assert property (p_restart)
        else $error("writing zero to halted did not restart");

    property p_opctl_reserved;
        PREADY && PSEL && !PWRITE && PADDR == `EDCM_OFF_OPCTL
            |-> PRDATA[31:4] == 28'h0000000 && !PRDATA[0];
    endproperty
    a_opctl_reserved: assert property (p_opctl_reserved)
        else $error("reserved operation control bit read nonzero");

    property p_rx_buf_mon;
        RX_BUF_MON.valid && !software_reset_bit
            |=> rx_buffer_write_address == $past(RX_BUF_MON.addr);
    endproperty
    a_rx_buf_mon: assert property (p_rx_buf_mon)
        else $error("receive buffer monitor not updated");

    property p_tx_desc_mon;
        TX_DESC_MON.valid && !software_reset_bit
            |=> tx_descriptor_fetch_address == $past(TX_DESC_MON.addr);
    endproperty
    a_tx_desc_mon: assert property (p_tx_desc_mon)
        else $error("transmit descriptor monitor not updated");

    property p_frame_pause;
        RX_FIFO_FRAMES > {1'b0, frame_count_threshold} |=> PAUSE_REQ;
    endproperty
    a_frame_pause: assert property (p_frame_pause)
        else $error("frame threshold reached without pause request");

    property p_byte_pause;
        byte_threshold_code == `EDCM_CODE_256
            && RX_FIFO_BYTES >= 10'h0C0 |=> PAUSE_REQ;
    endproperty
    a_byte_pause: assert property (p_byte_pause)
        else $error("byte threshold reached without pause request");

    property p_no_pause;
        !byte_hit && !frame_hit |=> !PAUSE_REQ;
    endproperty
    a_no_pause: assert property (p_no_pause)
        else $error("pause requested below both thresholds");

endmodule // edcm_top

`default_nettype wire

//--- edcm_far_model.sv
/*
 * Behavioural model of the transfer engine and receive FIFO beside the
 * control block: address snapshots, engine events and FIFO fill.
 * Assumes the bench calls its tasks one at a time from a single thread.
 */
`default_nettype none

module edcm_far_model (
    // clock
    input  wire logic                       clk,
    // engine permission from the block
    input  wire logic                       run,
    // toward the block
    output var edcm_pkg::edcm_addr_mon_s [3:0] mon,
    output var logic [3:0]                  evt,
    output var logic [9:0]                  fill_bytes,
    output var logic [3:0]                  fill_frames
);
    import edcm_pkg::*;

    // quiet start: no snapshot, no event, empty fifo
    initial begin
        mon = '0;
        evt = 4'h0;
        fill_bytes = 10'h000;
        fill_frames = 4'h0;
    end

    // one-cycle snapshot; a stopped engine takes none
    task automatic snap(input int k, input logic [31:0] ad);
        @(posedge clk);
        if (run === 1'b1) begin
            mon[k] <= {1'b1, ad};
        end
        @(posedge clk);
        mon[k] <= {1'b0, ~ad}; // address not held once valid drops
    endtask

    // one-cycle event: 0 underflow, 1 overflow, 2 bad address, 3 nmi
    task automatic fire(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt[k] <= 1'b0;
    endtask

    // new receive fifo occupancy
    task automatic fill(input logic [9:0] b, input logic [3:0] f);
        @(posedge clk);
        fill_bytes <= b;
        fill_frames <= f;
    endtask
endmodule // edcm_far_model

`default_nettype wire

//--- tb_edcm_top.sv
/*
 * Self-checking bench of the ethernet dma control and monitor block.
 * Assumes the far-side model file and the register header are compiled.
 */
`include "edcm_regs.svh"
`default_nettype none

module tb_edcm_top;
    timeunit 1ns;
    timeprecision 1ps;
    import edcm_pkg::*;

    logic             CORE_CLK, RST_N, PSEL, PENABLE, PWRITE;
    logic [7:0]       PADDR;
    logic [31:0]      PWDATA;
    wire logic [31:0] PRDATA;
    wire logic        PREADY, PSLVERR, DMA_RUN, PAUSE_REQ, IRQ;
    wire edcm_addr_mon_s [3:0] mon;
    wire logic [3:0]  evt, ff;
    wire logic [9:0]  fb;
    int               err_total, checks;
    logic [31:0]      d, a;
    logic             e;
    logic [2:0]       bc, fc;
    logic [9:0]       b;
    logic [3:0]       f;

    edcm_top i_dut (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_UNDERFLOW(evt[0]),
        .RX_OVERFLOW(evt[1]), .ADDR_ILLEGAL(evt[2]), .NMI(evt[3]),
        .RX_BUF_MON(mon[0]), .RX_DESC_MON(mon[1]), .TX_BUF_MON(mon[2]),
        .TX_DESC_MON(mon[3]), .RX_FIFO_BYTES(fb), .RX_FIFO_FRAMES(ff),
        .DMA_RUN(DMA_RUN), .PAUSE_REQ(PAUSE_REQ), .IRQ(IRQ));

    edcm_far_model i_far (
        .clk(CORE_CLK), .run(DMA_RUN), .mon(mon), .evt(evt),
        .fill_bytes(fb), .fill_frames(ff));

    // free-running 50 MHz clock
    initial begin
        CORE_CLK = 1'b0;
        forever #10 CORE_CLK = ~CORE_CLK;
    end

    // verdict and end of run
    task automatic conclude();
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bchk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // apb transfer; the request holds until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] ad,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic er);
        bit done;
        done = 1'b0;
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge CORE_CLK);
            done = (PREADY === 1'b1);
        end
        if (!done) begin
            err_total++;
            conclude();
        end else begin
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] r;
        logic        x;
        xfer(1'b1, ad, wd, r, x);
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] r;
        logic        x;
        xfer(1'b0, ad, 32'h0, r, x);
        chk(r, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    // pause expected from byte limit or stored frame count
    function automatic logic exp_pause(input logic [2:0] bcode,
            input logic [2:0] fcode, input logic [9:0] nb,
            input logic [3:0] nf);
        logic [9:0] lim;
        lim = (bcode == `EDCM_CODE_512) ? `EDCM_DEPTH_512 - `EDCM_HEADROOM
                                        : `EDCM_DEPTH_256 - `EDCM_HEADROOM;
        return (nb >= lim) || (nf >= {1'b0, fcode} + 4'h1);
    endfunction

    // main sequence
    initial begin
        {PSEL, PENABLE, PWRITE} = 3'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        RST_N = 1'b0;
        err_total = 0;
        checks = 0;
        d = $urandom(32'h477968C9);
        tick(4);
        RST_N <= 1'b1;
        // reset values
        rchk(`EDCM_OFF_OPCTL, 32'h0);
        for (int k = 0; k < 4; k++) begin
            rchk(8'(`EDCM_OFF_RX_BUF + 4 * k), 32'h0);
        end
        rchk(`EDCM_OFF_FC_THR, 32'h00070000);
        // reserved bits, address error and halted refuse ones
        wr(`EDCM_OFF_OPCTL, 32'hFFFFFFFF);
        rchk(`EDCM_OFF_OPCTL, 32'h8);
        // snapshots readable, monitors refuse writes
        for (int k = 0; k < 4; k++) begin
            a = $urandom;
            i_far.snap(k, a);
            tick(1);
            rchk(8'(`EDCM_OFF_RX_BUF + 4 * k), a);
            xfer(1'b1, 8'(`EDCM_OFF_RX_BUF + 4 * k), ~a, d, e);
            bchk(e, 1'b1);
            rchk(8'(`EDCM_OFF_RX_BUF + 4 * k), a);
        end
        xfer(1'b0, 8'h30, 32'h0, d, e);
        bchk(e, 1'b1);
        chk(d, 32'h0);
        // fifo error keeps running when not selected to halt
        wr(`EDCM_OFF_INT_MASK, 32'hF);
        wr(`EDCM_OFF_OPCTL, 32'h0);
        i_far.fire(0);
        tick(3);
        bchk(DMA_RUN, 1'b1);
        bchk(IRQ, 1'b1);
        rchk(`EDCM_OFF_INT_STAT, 32'h1);
        wr(`EDCM_OFF_INT_STAT, 32'h1);
        tick(2);
        bchk(IRQ, 1'b0);
        // fifo error halts when selected, restart by writing zero
        wr(`EDCM_OFF_OPCTL, 32'h8);
        i_far.fire(1);
        tick(3);
        bchk(DMA_RUN, 1'b0);
        rchk(`EDCM_OFF_OPCTL, 32'hA);
        wr(`EDCM_OFF_OPCTL, 32'h8);
        tick(2);
        bchk(DMA_RUN, 1'b1);
        // nmi halt, masked then unmasked interrupt
        wr(`EDCM_OFF_INT_MASK, 32'h0);
        wr(`EDCM_OFF_INT_STAT, 32'hF);
        wr(`EDCM_OFF_OPCTL, 32'h0);
        i_far.fire(3);
        tick(3);
        bchk(DMA_RUN, 1'b0);
        bchk(IRQ, 1'b0);
        rchk(`EDCM_OFF_OPCTL, 32'h2);
        wr(`EDCM_OFF_INT_MASK, 32'h4);
        tick(2);
        bchk(IRQ, 1'b1);
        wr(`EDCM_OFF_OPCTL, 32'h0);
        tick(2);
        bchk(DMA_RUN, 1'b1);
        // address error sticks until software reset
        i_far.fire(2);
        tick(3);
        bchk(DMA_RUN, 1'b0);
        rchk(`EDCM_OFF_OPCTL, 32'h4);
        wr(`EDCM_OFF_OPCTL, 32'h0);
        tick(2);
        rchk(`EDCM_OFF_OPCTL, 32'h4);
        bchk(DMA_RUN, 1'b0);
        wr(`EDCM_OFF_MODE, 32'h1);
        tick(2);
        rchk(`EDCM_OFF_OPCTL, 32'h0);
        bchk(DMA_RUN, 1'b1);
        // thresholds: boundary fills on passes with j[4] clear, random fills with j[4] set
        wr(`EDCM_OFF_FIFO_DEPTH, 32'h1);
        rchk(`EDCM_OFF_FIFO_DEPTH, 32'h1);
        for (int j = 0; j < 48; j++) begin
            bc = {2'h0, j[0]};
            fc = j[3:1];
            b = (bc == `EDCM_CODE_512) ? `EDCM_DEPTH_512 - `EDCM_HEADROOM
                                       : `EDCM_DEPTH_256 - `EDCM_HEADROOM;
            b = b - 10'($urandom_range(1, 0));
            f = {1'b0, fc} + 4'($urandom_range(1, 0));
            if (j[4]) begin
                b = 10'($urandom_range(511, 0));
                f = 4'($urandom_range(15, 0));
            end
            wr(`EDCM_OFF_FC_THR, {13'h0, fc, 13'h0, bc});
            rchk(`EDCM_OFF_FC_THR, {13'h0, fc, 13'h0, bc});
            i_far.fill(b, f);
            e = exp_pause(bc, fc, b, f);
            tick(3);
            bchk(PAUSE_REQ, e);
        end
        // a rising pause request sets its own status bit
        i_far.fill(10'h000, 4'h0);
        wr(`EDCM_OFF_FC_THR, 32'h00070000);
        wr(`EDCM_OFF_INT_STAT, 32'hF);
        i_far.fill(`EDCM_DEPTH_256 - `EDCM_HEADROOM, 4'h0);
        tick(3);
        bchk(PAUSE_REQ, 1'b1);
        rchk(`EDCM_OFF_INT_STAT, 32'h8);
        conclude();
    end
endmodule // tb_edcm_top

`default_nettype wire
